// >>> shared/port_status_pkg.sv
// Constants shared by the port status register and its input synchroniser
package port_status_pkg;

   // ---------------------------------------------------------------
   // Register address and data width
   // ---------------------------------------------------------------
   localparam int unsigned      ADDR_W           = 5;
   localparam int unsigned      DATA_W           = 16;
   localparam logic [4:0]       PORT_STATUS_ADDR = 5'h14;

   // ---------------------------------------------------------------
   // Field positions inside the register
   // ---------------------------------------------------------------
   localparam int unsigned      BIT_LINK         = 13;
   localparam int unsigned      BIT_DUPLEX       = 12;
   localparam int unsigned      BIT_SPEED        = 11;
   localparam int unsigned      BIT_AN_DONE      = 9;
   localparam int unsigned      BIT_PAGE_RX      = 8;
   localparam int unsigned      BIT_SPARE_HI     = 7;
   localparam int unsigned      BIT_DESCR_LOCK   = 6;
   localparam int unsigned      BIT_SYMBOL_ERR   = 5;
   localparam int unsigned      BIT_MLT3_ERR     = 4;
   localparam int unsigned      BIT_LOW_VOLT     = 2;
   localparam int unsigned      BIT_SPARE_LO     = 1;

   // ---------------------------------------------------------------
   // Source signal indices in the synchronised vector
   // ---------------------------------------------------------------
   localparam int unsigned      N_SRC            = 9;
   localparam int unsigned      SRC_LINK         = 0;
   localparam int unsigned      SRC_DUPLEX       = 1;
   localparam int unsigned      SRC_SPEED        = 2;
   localparam int unsigned      SRC_AN_DONE      = 3;
   localparam int unsigned      SRC_PAGE_RX      = 4;
   localparam int unsigned      SRC_DESCR_LOCK   = 5;
   localparam int unsigned      SRC_SYMBOL_ERR   = 6;
   localparam int unsigned      SRC_MLT3_ERR     = 7;
   localparam int unsigned      SRC_LOW_VOLT     = 8;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [8:0]       SRC_RESET        = 9'h000;
   localparam logic [2:0]       FLAG_RESET       = 3'h0;
   localparam logic [1:0]       SPARE_RESET      = 2'h0;
   localparam logic [15:0]      RDATA_RESET      = 16'h0000;

endpackage : port_status_pkg

// >>> shared/status_src_if.sv
// Carrier for synchronised status source levels
`timescale 1ns/1ps
interface status_src_if #(
   parameter int unsigned W = 9
);
   logic [W-1:0] level;
   modport producer (output level);
   modport consumer (input  level);
endinterface : status_src_if

// >>> core/status_sync.sv
// Three-stage synchroniser bank with agreement filter
`timescale 1ns/1ps
module status_sync
   import port_status_pkg::*;
#(
   parameter int unsigned W = N_SRC
) (
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   input  wire logic [W-1:0]  raw,
   status_src_if.producer     src
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // ---------------------------------------------------------------
   // Stage chain; stage1 feeds stage2 only
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= SRC_RESET;
         stage2 <= SRC_RESET;
         stage3 <= SRC_RESET;
      end else begin
         stage1 <= raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // ---------------------------------------------------------------
   // Per bit: accept a change once stage2 and stage3 agree
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         src.level <= SRC_RESET;
      end else begin
         src.level <= (stage2 & stage3) | (src.level & (stage2 | stage3));
      end
   end

endmodule : status_sync

// >>> core/port_status_register.sv
// Per-port status register of a 10/100 transceiver, management side
`timescale 1ns/1ps

// Contract
// - Bit 13 reads the live link state, 1 up and 0 down, without latching.
// - Bit 12 reads the duplex in use and bit 11 the speed in use, both tracking the present mode.
// - The speed bit reads 1 at 100 Mbps and 0 at 10 Mbps.
// - Bit 9 mirrors auto-negotiation complete, 0 after reset.
// - Bit 8 mirrors page received, 1 whenever the synchronised input is high.
// - Bit 6 shows descrambler lock in 100BASE-TX operation only, 0 otherwise and after reset.
// - Bit 5 latches high on a received symbol error that is high at two successive clk_sys edges.
// - Bit 4 latches high on an MLT-3 coding error that is high at two successive clk_sys edges.
// - Bit 2 latches high on a low-voltage fault of the main supply.
module port_status_register
   import port_status_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic               arst_n,
   input  wire logic               link_up_in,
   input  wire logic               full_duplex_in,
   input  wire logic               speed_100_in,
   input  wire logic               an_complete_in,
   input  wire logic               page_received_in,
   input  wire logic               descr_lock_in,
   input  wire logic               symbol_err_in,
   input  wire logic               mlt3_err_in,
   input  wire logic               low_volt_in,
   input  wire logic [ADDR_W-1:0]  mgmt_addr,
   input  wire logic               mgmt_rd,
   input  wire logic               mgmt_wr,
   input  wire logic [DATA_W-1:0]  mgmt_wdata,
   output logic      [DATA_W-1:0]  mgmt_rdata,
   output logic                    mgmt_rvalid
);

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // Source synchronisation
   // ---------------------------------------------------------------
   status_src_if #(.W(N_SRC)) src ();

   logic [N_SRC-1:0] raw;
   assign raw = {low_volt_in, mlt3_err_in, symbol_err_in, descr_lock_in, page_received_in,
                 an_complete_in, speed_100_in, full_duplex_in, link_up_in};

   status_sync #(.W(N_SRC)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .raw     (raw),
      .src     (src.producer)
   );

   logic [N_SRC-1:0] lvl;
   assign lvl = src.level;

   // ---------------------------------------------------------------
   // Access decode
   // ---------------------------------------------------------------
   logic rd_hit;
   logic wr_hit;
   assign rd_hit = mgmt_rd && (mgmt_addr == PORT_STATUS_ADDR);
   assign wr_hit = mgmt_wr && !mgmt_rd && (mgmt_addr == PORT_STATUS_ADDR);

   // ---------------------------------------------------------------
   // Latching-high error flags: symbol, MLT-3, low voltage
   // ---------------------------------------------------------------
   logic [2:0] flag;
   logic [2:0] flag_src;
   assign flag_src = {lvl[SRC_LOW_VOLT], lvl[SRC_MLT3_ERR], lvl[SRC_SYMBOL_ERR]};

   // Set beats the read clear, so an error in the read cycle is kept
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flag <= FLAG_RESET;
      end else begin
         flag <= flag_src | (flag & {3{!rd_hit}});
      end
   end

   // ---------------------------------------------------------------
   // Spare read/write bits; stored only so a write is harmless
   // ---------------------------------------------------------------
   logic [1:0] spare;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         spare <= SPARE_RESET;
      end else if (wr_hit) begin
         spare <= {mgmt_wdata[BIT_SPARE_HI], mgmt_wdata[BIT_SPARE_LO]};
      end
   end

   // ---------------------------------------------------------------
   // Read image
   // ---------------------------------------------------------------
   function automatic logic [DATA_W-1:0] build_image(
      input logic [N_SRC-1:0] l,
      input logic [2:0]       f,
      input logic [1:0]       s
   );
      logic [DATA_W-1:0] img;
      img                 = RDATA_RESET;
      img[BIT_LINK]       = l[SRC_LINK];
      img[BIT_DUPLEX]     = l[SRC_DUPLEX];
      img[BIT_SPEED]      = l[SRC_SPEED];
      img[BIT_AN_DONE]    = l[SRC_AN_DONE];
      img[BIT_PAGE_RX]    = l[SRC_PAGE_RX];
      // Lock only means something on the 100 Mbps path
      img[BIT_DESCR_LOCK] = l[SRC_DESCR_LOCK] & l[SRC_SPEED];
      img[BIT_SYMBOL_ERR] = f[0];
      img[BIT_MLT3_ERR]   = f[1];
      img[BIT_LOW_VOLT]   = f[2];
      img[BIT_SPARE_HI]   = s[1];
      img[BIT_SPARE_LO]   = s[0];
      return img;
   endfunction : build_image

   // ---------------------------------------------------------------
   // Read answer, one cycle after the strobe
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_rdata <= RDATA_RESET;
      end else if (rd_hit) begin
         mgmt_rdata <= build_image(lvl, flag, spare);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_rvalid <= 1'b0;
      end else begin
         mgmt_rvalid <= rd_hit;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   link_live_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_hit |=> mgmt_rdata[BIT_LINK] == $past(lvl[SRC_LINK]))
      else $error("Link bit does not show live link state");

   duplex_track_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_hit |=> mgmt_rdata[BIT_DUPLEX] == $past(lvl[SRC_DUPLEX]))
      else $error("Duplex bit does not track mode");

   speed_track_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_hit |=> mgmt_rdata[BIT_SPEED] == $past(lvl[SRC_SPEED]))
      else $error("Speed bit does not track mode");

   an_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_hit |=> mgmt_rdata[BIT_AN_DONE] == $past(lvl[SRC_AN_DONE]))
      else $error("Auto-negotiation bit mismatch");

   page_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_hit |=> mgmt_rdata[BIT_PAGE_RX] == $past(lvl[SRC_PAGE_RX]))
      else $error("Page received bit mismatch");

   lock_tx_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rd_hit && !lvl[SRC_SPEED]) |=> !mgmt_rdata[BIT_DESCR_LOCK])
      else $error("Lock shown outside 100 Mbps mode");

   symbol_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (lvl[SRC_SYMBOL_ERR] || (flag[0] && !rd_hit)) |=> flag[0])
      else $error("Symbol error not latched");

   mlt3_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (flag[1] && !rd_hit) |=> flag[1])
      else $error("MLT-3 flag dropped before read");

   volt_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      lvl[SRC_LOW_VOLT] |=> flag[2])
      else $error("Low-voltage flag not set");

   flag_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rd_hit && !flag_src[0]) |=> flag[0] == $past(flag_src[0]))
      else $error("Flag not returned to source after read");

   reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mgmt_rvalid |-> (mgmt_rdata[15:14] == 2'h0) && !mgmt_rdata[10] && !mgmt_rdata[3] && !mgmt_rdata[0])
      else $error("Read-only reserved bits not zero");

   rvalid_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_hit |=> mgmt_rvalid ##1 (mgmt_rvalid == $past(rd_hit)))
      else $error("Read answer timing wrong");

   spare_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_hit |=> (spare[1] == $past(mgmt_wdata[BIT_SPARE_HI])) && (spare[0] == $past(mgmt_wdata[BIT_SPARE_LO])))
      else $error("Spare bits not stored on write");

   unmapped_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mgmt_rd && (mgmt_addr != PORT_STATUS_ADDR)) |=> !mgmt_rvalid)
      else $error("Answer given for an unmapped address");

   link_up_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      rd_hit ##1 mgmt_rdata[BIT_LINK] && mgmt_rdata[BIT_SPEED]);

   error_clear_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      flag[0] ##1 rd_hit ##1 !flag[0]);

   set_on_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      rd_hit && flag_src[2] ##1 flag[2]);

   spare_write_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      wr_hit ##2 rd_hit);

   unmapped_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      mgmt_rd && (mgmt_addr != PORT_STATUS_ADDR));

endmodule : port_status_register

// >>> verif/mgmt_ctrl_model.sv
// Management controller model that issues register reads and writes
`timescale 1ns/1ps
module mgmt_ctrl_model
   import port_status_pkg::*;
(
   input  wire logic               go_rd,
   input  wire logic               go_wr,
   input  wire logic [ADDR_W-1:0]  req_addr,
   input  wire logic [DATA_W-1:0]  req_wdata,
   output logic      [ADDR_W-1:0]  mgmt_addr,
   output logic                    mgmt_rd,
   output logic                    mgmt_wr,
   output logic      [DATA_W-1:0]  mgmt_wdata
);
   // ---------------------------------------------------------------
   // Request path
   // ---------------------------------------------------------------
   assign mgmt_addr  = req_addr;
   assign mgmt_rd    = go_rd;
   // Never both strobes at once, the device would drop the write
   assign mgmt_wr    = go_wr & ~go_rd;
   assign mgmt_wdata = req_wdata & 16'h3f7d;
endmodule : mgmt_ctrl_model

// >>> verif/tb.sv
// Self-checking bench for the port status register
`timescale 1ns/1ps
module tb;
   import port_status_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic              clk_sys;
   logic              arst_n;
   logic [8:0]        src;
   logic              go_rd;
   logic              go_wr;
   logic [ADDR_W-1:0] req_addr;
   logic [DATA_W-1:0] req_wdata;
   logic [ADDR_W-1:0] mgmt_addr;
   logic              mgmt_rd;
   logic              mgmt_wr;
   logic [DATA_W-1:0] mgmt_wdata;
   logic [DATA_W-1:0] mgmt_rdata;
   logic              mgmt_rvalid;
   logic [31:0]       seed;
   logic [2:0]        sticky;
   logic [DATA_W-1:0] held;
   logic              hit;
   int                bad_count;
   int                checks;

   mgmt_ctrl_model partner (.go_rd(go_rd), .go_wr(go_wr), .req_addr(req_addr), .req_wdata(req_wdata),
      .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata));

   port_status_register uut (.clk_sys(clk_sys), .arst_n(arst_n), .link_up_in(src[SRC_LINK]),
      .full_duplex_in(src[SRC_DUPLEX]), .speed_100_in(src[SRC_SPEED]), .an_complete_in(src[SRC_AN_DONE]),
      .page_received_in(src[SRC_PAGE_RX]), .descr_lock_in(src[SRC_DESCR_LOCK]),
      .symbol_err_in(src[SRC_SYMBOL_ERR]), .mlt3_err_in(src[SRC_MLT3_ERR]), .low_volt_in(src[SRC_LOW_VOLT]),
      .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // Expected image from source levels and latched flags
   function automatic logic [15:0] image(input logic [8:0] v, input logic [2:0] f);
      logic [15:0] r;
      r = 16'h0000;
      r[BIT_LINK]       = v[SRC_LINK];
      r[BIT_DUPLEX]     = v[SRC_DUPLEX];
      r[BIT_SPEED]      = v[SRC_SPEED];
      r[BIT_AN_DONE]    = v[SRC_AN_DONE];
      r[BIT_PAGE_RX]    = v[SRC_PAGE_RX];
      r[BIT_DESCR_LOCK] = v[SRC_DESCR_LOCK] & v[SRC_SPEED];
      r[BIT_SYMBOL_ERR] = f[0];
      r[BIT_MLT3_ERR]   = f[1];
      r[BIT_LOW_VOLT]   = f[2];
      return r;
   endfunction : image

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_clk

   // Answer is accepted right after the taking edge or at either of the two edges after it
   task automatic do_read(input logic [ADDR_W-1:0] a, output logic got);
      int n;
      got = 1'b0;
      wait_clk(1);
      go_rd    = 1'b1;
      req_addr = a;
      wait_clk(1);
      go_rd = 1'b0;
      for (n = 0; n < 3 && got !== 1'b1; n++) begin
         if (mgmt_rvalid === 1'b1) got = 1'b1;
         else wait_clk(1);
      end
   endtask : do_read

   task automatic read_check(input logic [15:0] exp);
      do_read(PORT_STATUS_ADDR, hit);
      if (hit !== 1'b1) begin
         bad_count++;
         give_verdict();
      end
      check(mgmt_rdata, exp);
   endtask : read_check

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      arst_n = 1'b0; src = 9'h000; go_rd = 1'b0; go_wr = 1'b0;
      req_addr = 5'h00; req_wdata = 16'h0000; seed = 32'h0001116f;
      bad_count = 0; checks = 0; sticky = 3'h0;
      wait_clk(4);
      arst_n = 1'b1;
      wait_clk(8);
      read_check(16'h0000);
      $display("Test reset values done");
      // Each latched flag: short event, then two reads
      for (int i = 0; i < 3; i++) begin
         src[SRC_SYMBOL_ERR + i] = 1'b1;
         wait_clk(6);
         src[SRC_SYMBOL_ERR + i] = 1'b0;
         wait_clk(8);
         read_check(image(src, 3'h1 << i));
         read_check(image(src, 3'h0));
      end
      $display("Test latched flags done");
      // Unmapped address must give no answer and leave data alone
      held = mgmt_rdata;
      do_read(5'h13, hit);
      check({15'h0000, hit}, 16'h0000);
      check(mgmt_rdata, held);
      wait_clk(1);
      go_wr = 1'b1; req_addr = PORT_STATUS_ADDR; req_wdata = 16'hffff;
      wait_clk(1);
      go_wr = 1'b0;
      read_check(image(src, 3'h0));
      $display("Test unmapped and write done");
      // Random source levels, flags accumulate between reads
      for (int k = 0; k < 60; k++) begin
         seed = lfsr_next(seed);
         src  = seed[8:0];
         if (k % 5 == 0) src[SRC_LOW_VOLT] = 1'b0;
         wait_clk(8);
         read_check(image(src, sticky | src[8:6]));
         sticky = src[8:6];
      end
      $display("Test random levels done");
      give_verdict();
   end
endmodule : tb
